// >>> pft_table_access.sv
// Table read/write and self-timed write/erase sequencer for program flash
// Behaviour
// - Reads are single bytes, programs are 8-byte blocks, erases are 64-byte rows.
// - No bulk erase can be started; only row erases exist.
// - Fetch stalls during write or erase; the programming timer ends it.
// - Any byte value is accepted for programming, unchecked.
// - Table transfers pass one byte at a time through the byte latch.
// - Table writes fill holding registers; a long write commits them.
// - Pointer bits 2..0 pick the holding register on a table write.
// - Pointer bits 21..3 pick the 8-byte block at long write start.
// - Pointer bits 21..6 pick the erased row; bits 5..0 ignored.
// - Table reads use all 22 pointer bits.
// - Pointer is three byte registers forming a 22-bit value.
// - Table ops keep, post-increment, post-decrement or pre-increment the pointer.
// - Automatic pointer steps touch only the low 21 bits.
// - Unlock register stores nothing and reads as zero.
// - Program space select bit 7 picks program flash or data EEPROM.
// - Config space select bit 6 overrides bit 7 when set.
// - Row erase enable bit 4 turns next program-space start into an erase, clears after.
// - Write permit bit 2 gates writes and erases; clear at power-up.
// - Reset cutting a write sets the abort flag; space selects kept.
// - Write-start bit 1 set-only by software, cleared by hardware at end.
// - Completion sets the memory-done flag until software clears it.
// - Read-start bit 0 reads EEPROM one cycle; not settable in program space.
// - A block write or row erase stalls about 2 ms.
module pft_table_access
    import pft_pkg::*;
#(
    parameter int PROG_CYCLES = PFT_PROG_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic ext_reset_i,
    input wire logic wdt_reset_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [11:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic tbl_req_i,
    input wire logic tbl_write_i,
    input wire logic [1:0] tbl_mode_i,
    output logic tbl_done_o,
    output logic pm_rd_o,
    output logic [20:0] pm_addr_o,
    input wire logic [15:0] pm_rdata_i,
    output logic flash_prog_o,
    output logic flash_erase_o,
    output logic [21:0] flash_addr_o,
    output logic [1:0] flash_space_o,
    output logic [63:0] flash_wdata_o,
    output logic ee_rd_o,
    output logic fetch_stall_o,
    input wire logic done_flag_clr_i,
    output logic memory_done_flag_o
);

    typedef struct packed {
        pft_state_e state;
        logic [21:0] ptr;
        logic [7:0] latch;
        logic pgd;
        logic config_space_select;
        logic free;
        logic abort;
        logic permit;
        logic wr;
        logic rd;
        pft_unlock_e unlock;
        logic erasing;
        logic rd_lsb;
        logic [7:0] rdata;
        logic tbl_done;
        logic pm_rd;
        logic [20:0] pm_addr;
        logic flash_prog;
        logic flash_erase;
        logic [21:0] flash_addr;
        logic [1:0] space;
        logic ee_rd;
        logic stall;
        logic done_flag;
    } pft_state_s;

    pft_state_s st;
    pft_state_s next_st;
    logic soft_rst;
    logic tmr_start;
    logic tmr_done;
    logic hold_we;
    logic [2:0] hold_idx;
    logic [21:0] op_addr;
    logic [1:0] tgt_space;
    logic [7:0] ctl_view;

    assign soft_rst = ext_reset_i || wdt_reset_i;

    // Control register as software reads it; bit 5 reads zero
    assign ctl_view = {st.pgd, st.config_space_select, 1'b0, st.free, st.abort, st.permit, st.wr, st.rd};

    // Access address, pre-increment steps the low 21 bits only
    assign op_addr = (tbl_mode_i == PFT_MODE_PREINC)
        ? {st.ptr[21], st.ptr[20:0] + 21'h000001} : st.ptr;

    // Target space of a start, from the select bits being written
    assign tgt_space = sfr_wdata_i[PFT_BIT_CONFIG_SPACE_SELECT] ? PFT_SPACE_CONFIG
        : (sfr_wdata_i[PFT_BIT_PGD] ? PFT_SPACE_PROGRAM : PFT_SPACE_EEPROM);

    pft_hold_regs u_hold (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .we_i(hold_we),
        .idx_i(hold_idx),
        .wdata_i(st.latch),
        .data_o(flash_wdata_o)
    );

    pft_prog_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_timer (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .start_i(tmr_start),
        .clr_i(soft_rst),
        .done_o(tmr_done)
    );

    // Sequencer and register file next state
    always_comb begin
        next_st = st;
        next_st.tbl_done = 1'b0;
        next_st.pm_rd = 1'b0;
        next_st.flash_prog = 1'b0;
        next_st.flash_erase = 1'b0;
        next_st.ee_rd = 1'b0;
        next_st.rd = 1'b0;
        hold_we = 1'b0;
        hold_idx = op_addr[2:0];
        tmr_start = 1'b0;
        if (done_flag_clr_i) begin
            next_st.done_flag = 1'b0;
        end
        // Register reads, answered one cycle later
        if (sfr_rd_i) begin
            case (sfr_addr_i)
                PFT_ADDR_CTRL: next_st.rdata = ctl_view;
                PFT_ADDR_UNLOCK: next_st.rdata = PFT_BYTE_ZERO;
                PFT_ADDR_LATCH: next_st.rdata = st.latch;
                PFT_ADDR_PTR_LOW: next_st.rdata = st.ptr[7:0];
                PFT_ADDR_PTR_HIGH: next_st.rdata = st.ptr[15:8];
                PFT_ADDR_PTR_UPPER: next_st.rdata = {2'b00, st.ptr[21:16]};
                default: next_st.rdata = PFT_BYTE_ZERO;
            endcase
        end
        case (st.state)
            PFT_ST_IDLE: begin
                if (sfr_wr_i) begin
                    next_st.unlock = PFT_UL_IDLE;
                    case (sfr_addr_i)
                        PFT_ADDR_CTRL: begin
                            next_st.pgd = sfr_wdata_i[PFT_BIT_PGD];
                            next_st.config_space_select = sfr_wdata_i[PFT_BIT_CONFIG_SPACE_SELECT];
                            next_st.free = sfr_wdata_i[PFT_BIT_FREE];
                            next_st.abort = sfr_wdata_i[PFT_BIT_ABORT];
                            next_st.permit = sfr_wdata_i[PFT_BIT_PERMIT];
                            // Read start only in data EEPROM space, refused when program or config space is selected
                            if (sfr_wdata_i[PFT_BIT_RD] && !next_st.pgd && !next_st.config_space_select) begin
                                next_st.rd = 1'b1;
                                next_st.ee_rd = 1'b1;
                            end
                            // Start needs permit and a completed unlock
                            if (sfr_wdata_i[PFT_BIT_WR] && next_st.permit
                                && st.unlock == PFT_UL_ARMED) begin
                                next_st.wr = 1'b1;
                                next_st.state = PFT_ST_LONG;
                                next_st.stall = 1'b1;
                                next_st.space = tgt_space;
                                tmr_start = 1'b1;
                                // Row erase only; no bulk erase path exists
                                if (next_st.free && tgt_space == PFT_SPACE_PROGRAM) begin
                                    next_st.erasing = 1'b1;
                                    next_st.flash_erase = 1'b1;
                                    next_st.flash_addr = {st.ptr[21:PFT_ROW_LSB], 6'h00};
                                end else begin
                                    next_st.erasing = 1'b0;
                                    next_st.flash_prog = 1'b1;
                                    next_st.flash_addr = {st.ptr[21:PFT_BLOCK_LSB], 3'h0};
                                end
                            end
                            // A refused start never raises write-start
                        end
                        PFT_ADDR_UNLOCK: begin
                            if (sfr_wdata_i == PFT_KEY_FIRST) begin
                                next_st.unlock = PFT_UL_FIRST;
                            end else if (sfr_wdata_i == PFT_KEY_SECOND
                                && st.unlock == PFT_UL_FIRST) begin
                                next_st.unlock = PFT_UL_ARMED;
                            end
                        end
                        PFT_ADDR_LATCH: next_st.latch = sfr_wdata_i;
                        PFT_ADDR_PTR_LOW: next_st.ptr[7:0] = sfr_wdata_i;
                        PFT_ADDR_PTR_HIGH: next_st.ptr[15:8] = sfr_wdata_i;
                        PFT_ADDR_PTR_UPPER: next_st.ptr[21:16] = sfr_wdata_i[5:0];
                        default: begin
                        end
                    endcase
                end else if (tbl_req_i) begin
                    // Pointer update variant
                    case (tbl_mode_i)
                        PFT_MODE_POSTINC: next_st.ptr[20:0] = st.ptr[20:0] + 21'h000001;
                        PFT_MODE_POSTDEC: next_st.ptr[20:0] = st.ptr[20:0] - 21'h000001;
                        PFT_MODE_PREINC: next_st.ptr = op_addr;
                        default: next_st.ptr = st.ptr;
                    endcase
                    if (tbl_write_i) begin
                        hold_we = 1'b1;
                        hold_idx = op_addr[2:0];
                        next_st.tbl_done = 1'b1;
                    end else begin
                        next_st.pm_rd = 1'b1;
                        next_st.pm_addr = op_addr[21:1];
                        next_st.rd_lsb = op_addr[0];
                        next_st.state = PFT_ST_RD_WAIT;
                    end
                end
            end
            PFT_ST_RD_WAIT: begin
                // One byte of the word into the latch
                next_st.latch = st.rd_lsb ? pm_rdata_i[15:8] : pm_rdata_i[7:0];
                next_st.tbl_done = 1'b1;
                next_st.state = PFT_ST_IDLE;
            end
            PFT_ST_LONG: begin
                // Timer ends the long write and releases fetch
                if (tmr_done) begin
                    next_st.wr = 1'b0;
                    next_st.stall = 1'b0;
                    next_st.done_flag = 1'b1;
                    next_st.state = PFT_ST_IDLE;
                    if (st.erasing) begin
                        next_st.free = 1'b0;
                    end
                end
            end
            default: next_st.state = PFT_ST_IDLE;
        endcase
        // Pin or watchdog reset; space selects survive for tracing
        if (soft_rst) begin
            if (st.state == PFT_ST_LONG) begin
                next_st.abort = 1'b1;
            end
            next_st.state = PFT_ST_IDLE;
            next_st.ptr = PFT_PTR_RST;
            next_st.latch = PFT_LATCH_RST;
            next_st.free = 1'b0;
            next_st.permit = 1'b0;
            next_st.wr = 1'b0;
            next_st.rd = 1'b0;
            next_st.unlock = PFT_UL_IDLE;
            next_st.stall = 1'b0;
            next_st.tbl_done = 1'b0;
            next_st.pm_rd = 1'b0;
            next_st.flash_prog = 1'b0;
            next_st.flash_erase = 1'b0;
            next_st.ee_rd = 1'b0;
            hold_we = 1'b0;
            tmr_start = 1'b0;
        end
    end

    // State register; power-on clears everything including the permit bit
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register; data bytes pass unchecked
    assign sfr_rdata_o = st.rdata;
    assign tbl_done_o = st.tbl_done;
    assign pm_rd_o = st.pm_rd;
    assign pm_addr_o = st.pm_addr;
    assign flash_prog_o = st.flash_prog;
    assign flash_erase_o = st.flash_erase;
    assign flash_addr_o = st.flash_addr;
    assign flash_space_o = st.space;
    assign ee_rd_o = st.ee_rd;
    assign fetch_stall_o = st.stall;
    assign memory_done_flag_o = st.done_flag;

    // Checks
    property p_start_unlocked;
        @(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        $rose(fetch_stall_o) |-> $past(st.unlock) == PFT_UL_ARMED && st.permit;
    endproperty
    a_start_unlocked: assert property (p_start_unlocked) else $error("start without unlock");

    property p_end_on_timer;
        @(posedge sys_clk_i) disable iff (rst_i || !ce_i || soft_rst)
        st.state == PFT_ST_LONG && tmr_done && !soft_rst
        |=> !fetch_stall_o && !st.wr && memory_done_flag_o;
    endproperty
    a_end_on_timer: assert property (p_end_on_timer) else $error("long write did not end");

    property p_wr_sticky;
        @(posedge sys_clk_i) disable iff (rst_i || !ce_i || soft_rst)
        st.wr && !tmr_done && !soft_rst |=> st.wr;
    endproperty
    a_wr_sticky: assert property (p_wr_sticky) else $error("write-start lost early");

    property p_unlock_zero;
        @(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        sfr_rd_i && sfr_addr_i == PFT_ADDR_UNLOCK |=> sfr_rdata_o == PFT_BYTE_ZERO;
    endproperty
    a_unlock_zero: assert property (p_unlock_zero) else $error("unlock read not zero");

    property p_rd_one_cycle;
        @(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        ee_rd_o |-> st.rd && !st.pgd ##1 !st.rd;
    endproperty
    a_rd_one_cycle: assert property (p_rd_one_cycle) else $error("read-start misbehaved");

    property p_postinc_top;
        @(posedge sys_clk_i) disable iff (rst_i || !ce_i || soft_rst)
        st.state == PFT_ST_IDLE && tbl_req_i && !sfr_wr_i && tbl_mode_i == PFT_MODE_POSTINC
        |=> st.ptr[21] == $past(st.ptr[21]) && st.ptr[20:0] == $past(st.ptr[20:0]) + 21'h000001;
    endproperty
    a_postinc_top: assert property (p_postinc_top) else $error("pointer step wrong");

    property p_hold_index;
        @(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        hold_we && tbl_mode_i != PFT_MODE_PREINC |-> hold_idx == st.ptr[2:0];
    endproperty
    a_hold_index: assert property (p_hold_index) else $error("holding index wrong");

    property p_erase_row;
        @(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        flash_erase_o |-> flash_addr_o[5:0] == 6'h00 && st.free && st.space == PFT_SPACE_PROGRAM;
    endproperty
    a_erase_row: assert property (p_erase_row) else $error("erase address not a row");

    property p_free_clears;
        @(posedge sys_clk_i) disable iff (rst_i || !ce_i || soft_rst)
        st.state == PFT_ST_LONG && st.erasing && tmr_done && !soft_rst |=> !st.free;
    endproperty
    a_free_clears: assert property (p_free_clears) else $error("erase enable stuck");

    property p_abort_trace;
        @(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        soft_rst && st.state == PFT_ST_LONG
        |=> st.abort && st.pgd == $past(st.pgd) && st.config_space_select == $past(st.config_space_select) && !fetch_stall_o;
    endproperty
    a_abort_trace: assert property (p_abort_trace) else $error("abort not recorded");

    c_erase: cover property (@(posedge sys_clk_i) disable iff (rst_i) flash_erase_o);
    c_program: cover property (@(posedge sys_clk_i) disable iff (rst_i) flash_prog_o);
    c_table_read: cover property (@(posedge sys_clk_i) disable iff (rst_i) pm_rd_o ##1 tbl_done_o);
    c_abort: cover property (@(posedge sys_clk_i) disable iff (rst_i) fetch_stall_o && soft_rst);

endmodule : pft_table_access

// >>> pft_pkg.sv
// Constants, codes and types shared by the program flash table access block
package pft_pkg;

    // Register file addresses on the core's special function register port
    localparam logic [11:0] PFT_ADDR_CTRL = 12'hFA6;
    localparam logic [11:0] PFT_ADDR_UNLOCK = 12'hFA7;
    localparam logic [11:0] PFT_ADDR_LATCH = 12'hFF5;
    localparam logic [11:0] PFT_ADDR_PTR_LOW = 12'hFF6;
    localparam logic [11:0] PFT_ADDR_PTR_HIGH = 12'hFF7;
    localparam logic [11:0] PFT_ADDR_PTR_UPPER = 12'hFF8;

    // Control register bit positions
    localparam int PFT_BIT_PGD = 7;
    localparam int PFT_BIT_CONFIG_SPACE_SELECT = 6;
    localparam int PFT_BIT_FREE = 4;
    localparam int PFT_BIT_ABORT = 3;
    localparam int PFT_BIT_PERMIT = 2;
    localparam int PFT_BIT_WR = 1;
    localparam int PFT_BIT_RD = 0;

    // Values after reset
    localparam logic [21:0] PFT_PTR_RST = 22'h000000;
    localparam logic [7:0] PFT_LATCH_RST = 8'h00;
    localparam logic [7:0] PFT_BYTE_ZERO = 8'h00;

    // Unlock keys
    localparam logic [7:0] PFT_KEY_FIRST = 8'h55;
    localparam logic [7:0] PFT_KEY_SECOND = 8'hAA;

    // Geometry: 8 holding bytes, 64-byte erase rows
    localparam int PFT_HOLD_N = 8;
    localparam int PFT_BLOCK_LSB = 3;
    localparam int PFT_ROW_LSB = 6;

    // Programming time and its cycle count at 250 MHz
    localparam int PFT_PROG_TIME_NS = 2000000;
    localparam int PFT_CLK_PERIOD_NS = 4;
    localparam int PFT_PROG_CYCLES = PFT_PROG_TIME_NS / PFT_CLK_PERIOD_NS;
    localparam int PFT_TMR_W = 20;

    // Pointer update variants of a table operation
    localparam logic [1:0] PFT_MODE_KEEP = 2'h0;
    localparam logic [1:0] PFT_MODE_POSTINC = 2'h1;
    localparam logic [1:0] PFT_MODE_POSTDEC = 2'h2;
    localparam logic [1:0] PFT_MODE_PREINC = 2'h3;

    // Target memory space of a long write
    localparam logic [1:0] PFT_SPACE_EEPROM = 2'h0;
    localparam logic [1:0] PFT_SPACE_PROGRAM = 2'h1;
    localparam logic [1:0] PFT_SPACE_CONFIG = 2'h2;

    typedef enum logic [1:0] {
        PFT_UL_IDLE = 2'b00,
        PFT_UL_FIRST = 2'b01,
        PFT_UL_ARMED = 2'b10
    } pft_unlock_e;

    typedef enum logic [1:0] {
        PFT_ST_IDLE = 2'b00,
        PFT_ST_RD_WAIT = 2'b01,
        PFT_ST_LONG = 2'b10
    } pft_state_e;

endpackage : pft_pkg

// >>> pft_hold_regs.sv
// Eight-byte write holding memory loaded by table writes
module pft_hold_regs
    import pft_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic we_i,
    input wire logic [2:0] idx_i,
    input wire logic [7:0] wdata_i,
    output logic [63:0] data_o
);

    typedef struct packed {
        logic [PFT_HOLD_N-1:0][7:0] ent;
    } pft_hold_s;

    pft_hold_s st;
    pft_hold_s next_st;
    logic [PFT_HOLD_N-1:0] sel;

    // One select per entry
    genvar g;
    generate
        for (g = 0; g < PFT_HOLD_N; g++) begin : g_sel
            assign sel[g] = we_i && (idx_i == 3'(g));
        end
    endgenerate

    // Next entry contents
    always_comb begin
        next_st = st;
        for (int i = 0; i < PFT_HOLD_N; i++) begin
            if (sel[i]) begin
                next_st.ent[i] = wdata_i;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign data_o = st.ent;

endmodule : pft_hold_regs

// >>> pft_prog_timer.sv
// Programming timer that measures the self-timed long write
module pft_prog_timer
    import pft_pkg::*;
#(
    parameter int CYCLES = PFT_PROG_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic clr_i,
    output logic done_o
);

    typedef struct packed {
        logic [PFT_TMR_W-1:0] cnt;
        logic run;
        logic done;
    } pft_tmr_s;

    pft_tmr_s st;
    pft_tmr_s next_st;

    // Count down, pulse done at zero
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (clr_i) begin
            next_st.run = 1'b0;
        end else if (start_i) begin
            next_st.run = 1'b1;
            next_st.cnt = PFT_TMR_W'(CYCLES - 1);
        end else if (st.run) begin
            if (st.cnt == '0) begin
                next_st.run = 1'b0;
                next_st.done = 1'b1;
            end else begin
                next_st.cnt = st.cnt - 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign done_o = st.done;

endmodule : pft_prog_timer

// >>> pft_pmem_model.sv
// Program memory stand-in answering table read strobes
module pft_pmem_model
    import pft_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic pm_rd_i,
    input wire logic [20:0] pm_addr_i,
    output logic [15:0] pm_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] last = 16'h0000;
    // Word pattern: low address byte and its inverse
    wire logic [15:0] word = {~pm_addr_i[7:0], pm_addr_i[7:0]};
    // Keep the last word so an idle bus can show its inverse
    always_ff @(posedge sys_clk_i) begin
        if (pm_rd_i) begin
            last <= word;
        end
    end
    // Valid only while strobed, never a stale copy
    assign pm_rdata_o = pm_rd_i ? word : ~last;
endmodule : pft_pmem_model

// >>> tb_top.sv
// Self-checking bench for the table access block
module tb_top
    import pft_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P = 20;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, ext_reset_i = 1'b0, done_flag_clr_i = 1'b0;
    logic sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, tbl_req_i = 1'b0, tbl_write_i = 1'b0;
    logic [11:0] sfr_addr_i = 12'h000;
    logic [7:0] sfr_wdata_i = 8'h00, sfr_rdata_o, v, d;
    logic [1:0] tbl_mode_i = 2'h0, flash_space_o, m;
    logic tbl_done_o, pm_rd_o, flash_prog_o, flash_erase_o, ee_rd_o, fetch_stall_o;
    logic memory_done_flag_o, wdt_reset_i = 1'b0;
    logic [20:0] pm_addr_o;
    logic [15:0] pm_rdata_i;
    logic [21:0] flash_addr_o, ptr, a;
    logic [63:0] flash_wdata_o, hold;
    logic [23:0] t;
    int n_errors = 0, num_checks = 0, n;
    pft_table_access #(.PROG_CYCLES(P)) pft_table_access_inst (.sys_clk_i, .rst_i,
        .ce_i(1'b1), .ext_reset_i, .wdt_reset_i, .sfr_wr_i, .sfr_rd_i, .sfr_addr_i,
        .sfr_wdata_i, .sfr_rdata_o, .tbl_req_i, .tbl_write_i, .tbl_mode_i, .tbl_done_o,
        .pm_rd_o, .pm_addr_o, .pm_rdata_i, .flash_prog_o, .flash_erase_o, .flash_addr_o,
        .flash_space_o, .flash_wdata_o, .ee_rd_o, .fetch_stall_o, .done_flag_clr_i,
        .memory_done_flag_o);
    pft_pmem_model pft_pmem_model_inst (.sys_clk_i, .pm_rd_i(pm_rd_o),
        .pm_addr_i(pm_addr_o), .pm_rdata_o(pm_rdata_i));
    // Expected pointer after a table operation, top bit held
    function automatic logic [21:0] stp(input logic [21:0] p, input logic [1:0] k);
        logic [20:0] lo;
        case (k)
            PFT_MODE_KEEP: lo = p[20:0];
            PFT_MODE_POSTDEC: lo = p[20:0] - 21'h1;
            default: lo = p[20:0] + 21'h1;
        endcase
        return {p[21], lo};
    endfunction : stp
    task automatic report_and_stop;
        if (n_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk
    // Register bus cycles, one strobe cycle each
    task automatic wr(input logic [11:0] ad, input logic [7:0] dt);
        @(posedge sys_clk_i);
        sfr_wr_i <= 1'b1;
        sfr_addr_i <= ad;
        sfr_wdata_i <= dt;
        @(posedge sys_clk_i);
        sfr_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] ad);
        @(posedge sys_clk_i);
        sfr_rd_i <= 1'b1;
        sfr_addr_i <= ad;
        @(posedge sys_clk_i);
        sfr_rd_i <= 1'b0;
        @(posedge sys_clk_i);
        #1 v = sfr_rdata_o;
    endtask : rd
    task automatic cptr(input logic [21:0] e);
        rd(PFT_ADDR_PTR_LOW);
        t[7:0] = v;
        rd(PFT_ADDR_PTR_HIGH);
        t[15:8] = v;
        rd(PFT_ADDR_PTR_UPPER);
        t[23:16] = v;
        chk("ptr", {2'b00, e}, t);
    endtask : cptr
    task automatic tbl(input logic w, input logic [1:0] k);
        @(posedge sys_clk_i);
        tbl_req_i <= 1'b1;
        tbl_write_i <= w;
        tbl_mode_i <= k;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            tbl_req_i <= 1'b0;
            #1 n++;
            if (n == 1) chk("pm_rd", !w, pm_rd_o);
        end while (tbl_done_o !== 1'b1 && n < 4);
        if (n == 4) begin
            n_errors++;
            report_and_stop();
        end
    endtask : tbl
    // Clear the done flag, unlock, then write the control register
    task automatic lw(input logic [7:0] c);
        @(posedge sys_clk_i);
        done_flag_clr_i <= 1'b1;
        @(posedge sys_clk_i);
        done_flag_clr_i <= 1'b0;
        wr(PFT_ADDR_UNLOCK, PFT_KEY_FIRST);
        chk("flag_clr", 0, memory_done_flag_o);
        wr(PFT_ADDR_UNLOCK, PFT_KEY_SECOND);
        wr(PFT_ADDR_CTRL, c);
        #1;
    endtask : lw
    task automatic go(input logic [7:0] c, input logic [1:0] pe, input logic [21:0] ad);
        lw(c);
        chk("cmd", {pe, 1'b1}, {flash_prog_o, flash_erase_o, fetch_stall_o});
        chk("space", 1, flash_space_o);
        chk("addr", ad, flash_addr_o);
        chk("data", hold, flash_wdata_o);
        n = 1;
        while (n < 100) begin
            @(posedge sys_clk_i);
            #1 if (fetch_stall_o !== 1'b1) break;
            n++;
        end
        chk("stall", P + 1, n);
        chk("flag", 1, memory_done_flag_o);
        rd(PFT_ADDR_CTRL);
        chk("ctrl", 8'h84, v);
    endtask : go
    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        void'($urandom(32'h0383));
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd(PFT_ADDR_CTRL);
        chk("ctrl", 0, v);
        wr(PFT_ADDR_UNLOCK, PFT_KEY_FIRST);
        rd(PFT_ADDR_UNLOCK);
        chk("unlock", 0, v);
        // Table reads in every pointer mode, wrap corners first
        for (int i = 0; i < 16; i++) begin
            ptr = (i < 4) ? 22'h3FFFFF : ((i < 8) ? 22'h200000 : 22'($urandom));
            m = 2'(i);
            wr(PFT_ADDR_PTR_LOW, ptr[7:0]);
            wr(PFT_ADDR_PTR_HIGH, ptr[15:8]);
            wr(PFT_ADDR_PTR_UPPER, {2'b00, ptr[21:16]});
            tbl(1'b0, m);
            a = (m == PFT_MODE_PREINC) ? stp(ptr, m) : ptr;
            chk("pm_addr", a[21:1], pm_addr_o);
            rd(PFT_ADDR_LATCH);
            chk("latch", 8'(a[0] ? ~a[8:1] : a[8:1]), v);
            ptr = stp(ptr, m);
            cptr(ptr);
        end
        // Eight table writes, then a block program and a row erase
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            hold[{ptr[2:0], 3'b000} +: 8] = d;
            wr(PFT_ADDR_LATCH, d);
            tbl(1'b1, PFT_MODE_POSTINC);
            ptr = stp(ptr, PFT_MODE_POSTINC);
        end
        go(8'h86, 2'b10, {ptr[21:3], 3'b000});
        go(8'h96, 2'b01, {ptr[21:6], 6'h00});
        // Starts refused without unlock or without permit
        wr(PFT_ADDR_CTRL, 8'h86);
        #1 chk("cmd", 0, {flash_prog_o, flash_erase_o, fetch_stall_o});
        lw(8'h82);
        chk("cmd", 0, {flash_prog_o, flash_erase_o, fetch_stall_o});
        rd(PFT_ADDR_CTRL);
        chk("ctrl", 8'h80, v);
        // EEPROM read start, then refused in program space
        wr(PFT_ADDR_CTRL, 8'h01);
        #1 chk("ee_rd", 1, ee_rd_o);
        wr(PFT_ADDR_CTRL, 8'h81);
        rd(PFT_ADDR_CTRL);
        chk("ctrl", 8'h80, v);
        // Configuration write cut short by the reset pin, then by the watchdog
        for (int j = 0; j < 2; j++) begin
            lw(8'hC6);
            chk("space", 2, flash_space_o);
            repeat (3) @(posedge sys_clk_i);
            {wdt_reset_i, ext_reset_i} <= j ? 2'b10 : 2'b01;
            @(posedge sys_clk_i);
            {wdt_reset_i, ext_reset_i} <= 2'b00;
            rd(PFT_ADDR_CTRL);
            chk("ctrl", 8'hC8, v);
            chk("stall", 0, fetch_stall_o);
        end
        report_and_stop();
    end
endmodule : tb_top
